/* File: include/kms_pkg.sv */
// Summary of operation
// - new key while pending: overrun low, overwrite code
// - scan code read has no side effect
// - status reset strobe write clears overrun
// - six-bit counter, compare register, four states
// - one key per scan tick, 64 ticks
// - idle, key down: latch compare, debounce
// - debounce, match, key up: back to idle
// - debounce, mismatch, key down: back to idle
// - match and down: irq, held, code, confirmed
// - confirmed, match, key up: release debounce
// - release debounce, match, up: released, idle
// - debounce off: every compare matches
// - control at 00, shift 10, break 30
// - modifier latches feed shift status, code bits
// - modifiers bypass debounce, held bit, overrun
// - break irq on down edge if enabled
// - scan disabled: idle, counter reset, held bit one
// - disabled keeps code, irqs, frozen shift
// - no break detection while disabled
// - counter high bits drive, low bits sense
// - no hardware auto-repeat
// - code bits 0-5; keyboard irq needs enable
// - code bits 6-7 change only with new code
package kms_pkg;
    // =========================================
    // register map (byte addresses)
    localparam logic [7:0] KMS_OFF_SCAN_CODE = 8'h00;
    localparam logic [7:0] KMS_OFF_KEY_STAT  = 8'h04;
    localparam logic [7:0] KMS_OFF_STAT_RST  = 8'h08;
    localparam logic [7:0] KMS_OFF_CONTROL   = 8'h0c;
    localparam logic [7:0] KMS_OFF_IRQ_PEND  = 8'h10;
    localparam logic [7:0] KMS_OFF_IRQ_EN    = 8'h14;
    // =========================================
    // field positions
    localparam int KMS_CTL_DEBOUNCE  = 0;
    localparam int KMS_CTL_SCAN_EN   = 1;
    localparam int KMS_STAT_HELD_N   = 2;
    localparam int KMS_STAT_SHIFT_N  = 3;
    localparam int KMS_STAT_OVR_N    = 6;
    localparam int KMS_IRQ_KEY       = 6;
    localparam int KMS_IRQ_BREAK     = 7;
    // =========================================
    // reset values and scan codes
    localparam logic [1:0] KMS_CTL_RESET  = 2'h3;
    localparam logic [7:0] KMS_IRQ_EN_RST = 8'h00;
    localparam logic [5:0] KMS_CODE_CTRL  = 6'h00;
    localparam logic [5:0] KMS_CODE_SHIFT = 6'h10;
    localparam logic [5:0] KMS_CODE_BREAK = 6'h30;
    // =========================================
    // timing
    localparam int KMS_CLK_HZ       = 200000000;
    localparam int KMS_SCAN_HZ      = 15000;
    localparam int KMS_TICK_CYCLES  = KMS_CLK_HZ / KMS_SCAN_HZ;
    typedef enum logic [1:0] {
        KMS_IDLE,
        KMS_PRESS_DB,
        KMS_CONFIRMED,
        KMS_RELEASE_DB
    } kms_state_t;
endpackage

/* File: rtl/kms_scanner.sv */
`timescale 1ns/1ps
module kms_scanner #(
    parameter int TICK_CYCLES = kms_pkg::KMS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // key matrix
    output logic      [2:0]  matrix_drive,
    output logic      [2:0]  matrix_sense_sel,
    input  wire logic        key_down,
    input  wire logic        modifier_return_line,
    // interrupt request level
    output logic             irq
);
    import kms_pkg::*;

    // =========================================
    // state
    logic [31:0]     tick_cnt_q;
    logic            tick;
    logic [5:0]      key_cnt_q;
    logic [5:0]      cmp_q;
    kms_state_t      state_q;
    logic [7:0]      latched_scan_code;
    logic            held_n_q;
    logic            ovr_n_q;
    logic            ctrl_lat_q;
    logic            shift_lat_q;
    logic            break_prev_q;
    logic [1:0]      port_control;
    logic [7:0]      irq_enable_mask;
    logic [7:0]      irq_pending_flags;
    logic            scan_en;
    logic            match;
    logic            confirm;
    logic            break_edge;
    logic            wr;
    logic            clr_key_irq;
    logic            clr_brk_irq;

    assign scan_en = port_control[KMS_CTL_SCAN_EN];
    assign match   = !port_control[KMS_CTL_DEBOUNCE] || (key_cnt_q == cmp_q);
    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |irq_pending_flags;

    // =========================================
    // scan tick divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'd1;
        end
    end
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    // =========================================
    // key counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_cnt_q <= '0;
        end else if (!scan_en) begin
            key_cnt_q <= '0;
        end else if (tick) begin
            key_cnt_q <= key_cnt_q + 6'h01;
        end
    end
    assign matrix_drive     = key_cnt_q[5:3];
    assign matrix_sense_sel = key_cnt_q[2:0];

    // =========================================
    // debounce machine; no repeat logic on purpose
    assign confirm = scan_en && tick && state_q == KMS_PRESS_DB && match && key_down;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= KMS_IDLE;
            cmp_q   <= '0;
        end else if (!scan_en) begin
            state_q <= KMS_IDLE;
        end else if (tick) begin
            case (state_q)
                KMS_IDLE: begin
                    if (key_down) begin
                        cmp_q   <= key_cnt_q;
                        state_q <= KMS_PRESS_DB;
                    end
                end
                KMS_PRESS_DB: begin
                    if (match && key_down) begin
                        state_q <= KMS_CONFIRMED;
                    end else if (match || key_down) begin
                        state_q <= KMS_IDLE;
                    end
                end
                KMS_CONFIRMED: begin
                    if (match && !key_down) begin
                        state_q <= KMS_RELEASE_DB;
                    end
                end
                KMS_RELEASE_DB: begin
                    if (match && !key_down) begin
                        state_q <= KMS_IDLE;
                    end
                end
                default: state_q <= KMS_IDLE;
            endcase
        end
    end

    // =========================================
    // key held status (active low)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_n_q <= 1'b1;
        end else if (!scan_en) begin
            held_n_q <= 1'b1;
        end else if (confirm) begin
            held_n_q <= 1'b0;
        end else if (tick && state_q == KMS_RELEASE_DB && match && !key_down) begin
            held_n_q <= 1'b1;
        end
    end

    // =========================================
    // scan code latch; modifiers only copied with a new code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_scan_code <= '0;
        end else if (confirm) begin
            latched_scan_code <= {ctrl_lat_q, shift_lat_q, key_cnt_q};
        end
    end

    // =========================================
    // overrun: strobe clear loses to a same-cycle overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_n_q <= 1'b1;
        end else if (confirm && irq_pending_flags[KMS_IRQ_KEY]) begin
            ovr_n_q <= 1'b0;
        end else if (wr && paddr == KMS_OFF_STAT_RST) begin
            ovr_n_q <= 1'b1;
        end
    end

    // =========================================
    // modifier latches; sampled straight, outside the debounce path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_lat_q  <= 1'b0;
            shift_lat_q <= 1'b0;
        end else if (scan_en && tick) begin
            if (key_cnt_q == KMS_CODE_CTRL) begin
                ctrl_lat_q <= modifier_return_line;
            end
            if (key_cnt_q == KMS_CODE_SHIFT) begin
                shift_lat_q <= modifier_return_line;
            end
        end
    end

    // =========================================
    // break edge detect
    assign break_edge = scan_en && tick && key_cnt_q == KMS_CODE_BREAK
                        && modifier_return_line && !break_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_prev_q <= 1'b0;
        end else if (scan_en && tick && key_cnt_q == KMS_CODE_BREAK) begin
            break_prev_q <= modifier_return_line;
        end
    end

    // =========================================
    // pending flags: writing 0 to an enable bit clears its flag; set wins
    assign clr_key_irq = wr && paddr == KMS_OFF_IRQ_EN && !pwdata[KMS_IRQ_KEY];
    assign clr_brk_irq = wr && paddr == KMS_OFF_IRQ_EN && !pwdata[KMS_IRQ_BREAK];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending_flags <= '0;
        end else begin
            if (confirm && irq_enable_mask[KMS_IRQ_KEY]) begin
                irq_pending_flags[KMS_IRQ_KEY] <= 1'b1;
            end else if (clr_key_irq) begin
                irq_pending_flags[KMS_IRQ_KEY] <= 1'b0;
            end
            if (break_edge && irq_enable_mask[KMS_IRQ_BREAK]) begin
                irq_pending_flags[KMS_IRQ_BREAK] <= 1'b1;
            end else if (clr_brk_irq) begin
                irq_pending_flags[KMS_IRQ_BREAK] <= 1'b0;
            end
        end
    end

    // =========================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_control    <= KMS_CTL_RESET;
            irq_enable_mask <= KMS_IRQ_EN_RST;
        end else if (wr) begin
            if (paddr == KMS_OFF_CONTROL) begin
                port_control <= pwdata[1:0];
            end
            if (paddr == KMS_OFF_IRQ_EN) begin
                irq_enable_mask <= pwdata[7:0];
            end
        end
    end

    // =========================================
    // read data; reads change no state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                KMS_OFF_SCAN_CODE: prdata <= {24'h0, latched_scan_code};
                KMS_OFF_KEY_STAT:  prdata <= {24'h0, 1'b1, ovr_n_q, 2'h3,
                                              !shift_lat_q, held_n_q, 2'h3};
                KMS_OFF_CONTROL:   prdata <= {30'h0, port_control};
                KMS_OFF_IRQ_PEND:  prdata <= {24'h0, irq_pending_flags};
                KMS_OFF_IRQ_EN:    prdata <= {24'h0, irq_enable_mask};
                default:           prdata <= 32'h0;
            endcase
        end
    end

endmodule // kms_scanner

/* File: test/kms_scanner_props.sv */
`timescale 1ns/1ps
module kms_scanner_props
    import kms_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // matrix and irq
    input wire logic [2:0]  matrix_drive,
    input wire logic [2:0]  matrix_sense_sel,
    input wire logic        key_down,
    input wire logic        modifier_return_line,
    input wire logic        irq
);
    // =========================================
    // the counter is seen only through the matrix lines
    wire [5:0] pos;
    assign pos = {matrix_drive, matrix_sense_sel};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_count_step: assert property ($changed(pos) |-> pos == $past(pos) + 6'h1 || pos == 6'h0)
        else $error("scan position jumped");
    // limitation: assumes TICK_CYCLES of at least 4
    // a scan-enable write may pull the counter to zero at any edge
    chk_one_per_tick: assert property (pos == $past(pos) + 6'h1 |=> (pos == $past(pos) || pos == 6'h0) [*3])
        else $error("scan position moved twice within a tick");
    chk_irq_kept: assert property ($fell(irq) |-> $past(psel && penable && pwrite && paddr == KMS_OFF_IRQ_EN))
        else $error("irq dropped without a mask write");
    chk_rdata_held: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
        else $error("read data moved outside a read");
    chk_unmapped_zero: assert property (psel && penable && !pwrite && paddr > KMS_OFF_IRQ_EN |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_disable_reset: assert property (psel && penable && pwrite && paddr == KMS_OFF_CONTROL
        && !pwdata[KMS_CTL_SCAN_EN] |-> ##[1:3] (pos == 6'h0) [*3])
        else $error("counter not held in reset while disabled");
    chk_ready_high: assert property (pready == 1'b1)
        else $error("pready low");
    chk_no_error: assert property (pslverr == 1'b0)
        else $error("pslverr high");
    cov_irq_rise: cover property ($rose(irq));
    cov_irq_fall: cover property ($fell(irq));
    cov_wrap: cover property (pos == 6'h3f ##[1:8] pos == 6'h0);
endmodule // kms_scanner_props

bind kms_scanner kms_scanner_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .matrix_drive(matrix_drive), .matrix_sense_sel(matrix_sense_sel), .key_down(key_down),
    .modifier_return_line(modifier_return_line), .irq(irq));

/* File: test/kms_key_matrix.sv */
`timescale 1ns/1ps
module kms_key_matrix (
    // matrix side
    input wire logic [2:0] matrix_drive,
    input wire logic [2:0] matrix_sense_sel,
    output logic           key_down,
    output logic           modifier_return_line,
    // keys held by the bench
    input wire logic       key_held,
    input wire logic [5:0] key_code,
    input wire logic       ctrl_held,
    input wire logic       shift_held,
    input wire logic       break_held
);
    // =========================================
    // one plain key; modifiers share rows 0, 2 and 6 on their own return line
    assign key_down = key_held && {matrix_drive, matrix_sense_sel} == key_code;
    assign modifier_return_line = (matrix_drive == 3'h0 && ctrl_held)
        || (matrix_drive == 3'h2 && shift_held) || (matrix_drive == 3'h6 && break_held);
endmodule // kms_key_matrix

/* File: test/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) cmp(32'(g), 32'(e))
module tb;
    import kms_pkg::*;
    localparam int TICK = 4;
    localparam int SCAN1 = 64 * TICK + 50;
    localparam int SCAN2 = 2 * 64 * TICK + 200;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  drv, sns;
    logic        kd, mrl, key_held, ctrl_held, shift_held, break_held;
    logic [5:0]  key_code;
    int          bad_count = 0;
    int          checked = 0;
    kms_scanner #(.TICK_CYCLES(TICK)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .matrix_drive(drv), .matrix_sense_sel(sns),
        .key_down(kd), .modifier_return_line(mrl), .irq(irq));
    kms_key_matrix i_keys (.matrix_drive(drv), .matrix_sense_sel(sns), .key_down(kd),
        .modifier_return_line(mrl), .key_held(key_held), .key_code(key_code),
        .ctrl_held(ctrl_held), .shift_held(shift_held), .break_held(break_held));
    initial forever #2.5 pclk = ~pclk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // =========================================
    // apb master: hold everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        `CHK(r & m, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        #150000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {key_held, ctrl_held, shift_held, break_held, key_code} = '0;
        idle(20);
        presetn <= 1'b1;
        rdc(KMS_OFF_CONTROL, 32'h3, 32'h3);
        rdc(KMS_OFF_IRQ_EN, 32'hff, 32'h0);
        rdc(8'h20, 32'hffffffff, 32'h0);
        // mask clear: key latched but no pending flag
        shift_held <= 1'b1;
        key_code <= 6'h2a;
        key_held <= 1'b1;
        idle(SCAN2);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h6a);
        rdc(KMS_OFF_IRQ_PEND, 32'hc0, 32'h0);
        rdc(KMS_OFF_KEY_STAT, 32'h4c, 32'h40);
        key_held <= 1'b0;
        shift_held <= 1'b0;
        idle(SCAN2);
        rdc(KMS_OFF_KEY_STAT, 32'h0c, 32'h0c);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h6a);
        wr(KMS_OFF_IRQ_EN, 32'h40);
        key_code <= 6'h15;
        key_held <= 1'b1;
        idle(SCAN2);
        `CHK(irq, 1'b1);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h15);
        rdc(KMS_OFF_IRQ_PEND, 32'hc0, 32'h40);
        // second key while pending gives overrun
        key_held <= 1'b0;
        idle(SCAN2);
        key_code <= 6'h33;
        key_held <= 1'b1;
        idle(SCAN2);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h33);
        rdc(KMS_OFF_KEY_STAT, 32'h44, 32'h00);
        wr(KMS_OFF_STAT_RST, 32'h0);
        rdc(KMS_OFF_KEY_STAT, 32'h40, 32'h40);
        // scan off with the key still held
        wr(KMS_OFF_CONTROL, 32'h1);
        idle(20);
        `CHK({drv, sns}, 6'h0);
        rdc(KMS_OFF_KEY_STAT, 32'h04, 32'h04);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h33);
        wr(KMS_OFF_IRQ_EN, 32'hc0);
        shift_held <= 1'b1;
        break_held <= 1'b1;
        idle(SCAN2);
        rdc(KMS_OFF_KEY_STAT, 32'h08, 32'h08);
        rdc(KMS_OFF_IRQ_PEND, 32'hc0, 32'h40);
        {shift_held, break_held, key_held} <= 3'h0;
        wr(KMS_OFF_IRQ_EN, 32'h40);
        wr(KMS_OFF_CONTROL, 32'h3);
        idle(SCAN1);
        // break edge needs the enable at the moment of the edge
        break_held <= 1'b1;
        idle(SCAN1);
        wr(KMS_OFF_IRQ_EN, 32'hc0);
        idle(SCAN1);
        rdc(KMS_OFF_IRQ_PEND, 32'h80, 32'h0);
        break_held <= 1'b0;
        idle(SCAN1);
        break_held <= 1'b1;
        idle(SCAN1);
        rdc(KMS_OFF_IRQ_PEND, 32'h80, 32'h80);
        wr(KMS_OFF_IRQ_EN, 32'h40);
        wr(KMS_OFF_IRQ_EN, 32'hc0);
        idle(SCAN1);
        rdc(KMS_OFF_IRQ_PEND, 32'h80, 32'h0);
        // debounce off: a lone key never confirms
        wr(KMS_OFF_CONTROL, 32'h2);
        key_code <= 6'h0c;
        key_held <= 1'b1;
        idle(SCAN2);
        rdc(KMS_OFF_KEY_STAT, 32'h04, 32'h04);
        rdc(KMS_OFF_SCAN_CODE, 32'hff, 32'h33);
        key_held <= 1'b0;
        wr(KMS_OFF_CONTROL, 32'h3);
        wr(KMS_OFF_IRQ_EN, 32'h0);
        idle(4);
        `CHK(irq, 1'b0);
        tally_and_finish();
    end
endmodule // tb
